// ===== sim/tb.sv
`include "dps_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t mismatch got %h want %h", $time, a, e); end end
    // ****************************************************************
    // Stimulus, reference state and monitors
    // ****************************************************************
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_xfer = 0, i_pattern_match = 0;
    logic [`DPS_ADDR_W-1:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, q, v;
    dps_pkg::dps_step_t i_xfer_bytes = 3'h1;
    dps_pkg::dps_len_t i_source_length = 16'h0000;
    logic [31:0] o_rdata;
    logic o_block_done, o_irq;
    logic [16:0] dlim, clim, slim;
    logic [15:0] sidx, didx, cidx;
    logic [3:0] st, msk;
    logic pat, exp_bd = 0, exp_irq = 0, chk = 0;
    logic [31:0] seed = 32'h0000_AB31;
    int fail_count = 0, total_checks = 0, cyc = 0;

    dps_channel uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_xfer(i_xfer), .i_xfer_bytes(i_xfer_bytes),
        .i_pattern_match(i_pattern_match), .i_source_length(i_source_length),
        .o_block_done(o_block_done), .o_irq(o_irq));

    initial
    begin
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // A stored zero stands for the full span, so the limit needs a seventeenth bit.
    function automatic logic [16:0] lim(input logic [15:0] len);
        return (len == 16'h0000) ? 17'h10000 : {1'b0, len};
    endfunction : lim

    task automatic adv(inout logic [15:0] idx, input logic [16:0] l, input logic [2:0] b,
                       output logic done, output logic half);
        logic [16:0] s;
        s = {1'b0, idx} + {14'h0, b};
        half = ({1'b0, idx} < {1'b0, l[16:1]}) && (s >= {1'b0, l[16:1]});
        done = s >= l;
        idx = done ? 16'h0000 : s[15:0];
    endtask : adv

    // Leaves the transfer inputs driven; the caller ends a burst with an idle step.
    task automatic step(input logic x, input logic [2:0] b, input logic m);
        logic sd, sh, dd, dh, cd, ch, clr, bd;
        i_xfer <= x;
        i_xfer_bytes <= b;
        i_pattern_match <= m;
        clr = m & pat;
        {sd, sh, dd, dh, cd, ch} = 6'h00;
        if (x)
            adv(didx, dlim, b, dd, dh);
        if (x && !clr)
        begin
            adv(sidx, slim, b, sd, sh);
            adv(cidx, clim, b, cd, ch);
        end
        if (clr)
        begin
            sidx = 16'h0000;
            cidx = 16'h0000;
        end
        bd = clr | ((dlim >= slim) ? dd : sd);
        st = st | {dd, dh, bd, cd};
        @(posedge i_clk);
        exp_bd = bd;
        exp_irq = |(st & msk);
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        if (a == `DPS_OFS_STAT) st = st & ~d[3:0];
        if (a == `DPS_OFS_MASK) msk = d[3:0];
        if (a == `DPS_OFS_CTRL) pat = d[0];
        if (a == `DPS_OFS_DLEN) dlim = lim(d[15:0]);
        if (a == `DPS_OFS_CLEN) clim = lim(d[15:0]);
        exp_bd = 1'b0;
        exp_irq = |(st & msk);
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        exp_bd = 1'b0;
        @(negedge i_clk);
        d = o_rdata;
        @(negedge i_clk);
        `CHK(o_rdata, 32'h0)
        @(posedge i_clk);
    endtask : rd

    // Write then read back with no gap between the two strobes.
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        if (a == `DPS_OFS_DLEN) dlim = lim(d[15:0]);
        if (a == `DPS_OFS_CLEN) clim = lim(d[15:0]);
        exp_bd = 1'b0;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
        @(posedge i_clk);
    endtask : wrrd

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask : rdc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    always @(negedge i_clk)
    begin
        if (chk)
        begin
            `CHK(o_block_done, exp_bd)
            `CHK(o_irq, exp_irq)
        end
    end

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {st, msk, pat, sidx, didx, cidx} = 57'h0;
        {dlim, clim, slim} = {17'h10000, 17'h10000, 17'h10000};
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk = 1'b1;
        for (int k = 0; k < 9; k++)
            rdc(8'(k * 4), 32'h0);
        wr(`DPS_OFS_DLEN, 32'hFFFF_1234);
        rdc(`DPS_OFS_DLEN, 32'h0000_1234);
        wr(`DPS_OFS_CLEN, 32'hABCD_0000);
        rdc(`DPS_OFS_CLEN, 32'h0);
        wr(`DPS_OFS_SPROG, 32'hFFFF_FFFF);
        rdc(`DPS_OFS_SPROG, 32'h0);
        wrrd(`DPS_OFS_DLEN, 32'h5A5A_0001, 32'h0000_0001);
        wrrd(`DPS_OFS_CLEN, 32'hFFFF_FFFF, 32'h0000_FFFF);
        // Equal lengths on both sides, so block completion follows the destination.
        i_source_length <= 16'h0004;
        slim = 17'h00004;
        wr(`DPS_OFS_DLEN, 32'h4);
        wr(`DPS_OFS_CLEN, 32'h2);
        wr(`DPS_OFS_MASK, 32'hF);
        step(1'b1, 3'h2, 1'b0);
        step(1'b0, 3'h1, 1'b0);
        rdc(`DPS_OFS_DPROG, 32'h2);
        rdc(`DPS_OFS_STAT, 32'h5);
        step(1'b1, 3'h2, 1'b0);
        step(1'b0, 3'h1, 1'b0);
        rdc(`DPS_OFS_STAT, 32'hF);
        rdc(`DPS_OFS_DPROG, 32'h0);
        wr(`DPS_OFS_STAT, 32'h5);
        rdc(`DPS_OFS_STAT, 32'hA);
        wr(`DPS_OFS_STAT, 32'hF);
        wr(`DPS_OFS_CTRL, 32'h1);
        step(1'b1, 3'h3, 1'b0);
        step(1'b1, 3'h1, 1'b1);
        step(1'b0, 3'h1, 1'b0);
        rdc(`DPS_OFS_SPROG, 32'h0);
        rdc(`DPS_OFS_CPROG, 32'h0);
        rdc(`DPS_OFS_DPROG, {16'h0, didx});
        wr(`DPS_OFS_CTRL, 32'h0);
        step(1'b1, 3'h1, 1'b0);
        step(1'b0, 3'h1, 1'b1);
        step(1'b0, 3'h1, 1'b0);
        rdc(`DPS_OFS_SPROG, {16'h0, sidx});
        for (int r = 0; r < 10; r++)
        begin
            v = rnd();
            wr(`DPS_OFS_DLEN, {v[31:16], 10'h0, v[5:0] + 6'h1});
            wr(`DPS_OFS_CLEN, {v[15:0], 13'h0, v[8:6]});
            wr(`DPS_OFS_CTRL, {31'h0, v[20]});
            wr(`DPS_OFS_MASK, {28'h0, v[27:24] & 4'hB});
            i_source_length <= {10'h0, v[14:9]};
            slim = lim({10'h0, v[14:9]});
            for (int n = 0; n < 24; n++)
            begin
                v = rnd();
                step(v[0] | v[1], 3'({1'b0, v[3:2]} + 3'h1), v[7:4] == 4'h0);
            end
            step(1'b0, 3'h1, 1'b0);
            rdc(`DPS_OFS_SPROG, {16'h0, sidx});
            rdc(`DPS_OFS_DPROG, {16'h0, didx});
            rdc(`DPS_OFS_CPROG, {16'h0, cidx});
            rd(`DPS_OFS_STAT, q);
            `CHK(q & 32'hB, {28'h0, st & 4'hB})
            wr(`DPS_OFS_STAT, 32'hF);
        end
        // Zero lengths mean the full span: 16390 four-byte transfers cover one pass and run six steps into the next.
        wr(`DPS_OFS_CTRL, 32'h0);
        wr(`DPS_OFS_DLEN, 32'h0);
        wr(`DPS_OFS_CLEN, 32'h0);
        i_source_length <= 16'h0000;
        slim = 17'h10000;
        for (int n = 0; n < 16390; n++)
            step(1'b1, 3'h4, 1'b0);
        step(1'b0, 3'h1, 1'b0);
        rdc(`DPS_OFS_DPROG, {16'h0, didx});
        rdc(`DPS_OFS_SPROG, {16'h0, sidx});
        rdc(`DPS_OFS_CPROG, {16'h0, cidx});
        tally_and_finish();
    end
endmodule : tb

// ===== src/dps_channel.sv
// ****************************************************************
// What this block does
// - Destination length 16 bits, zero means 65,536
// - Upper sixteen bits ignore writes, read zero
// - Read-only source byte index, 0 to 65,535
// - Read-only destination byte index, 0 to 65,535
// - Cell length 16 bits, zero means 65,536
// - Cell count: bytes since last cell done or match
// - Pattern match clears source index, cell count
// - Cell-done flag when cell length moved
// - Destination-done flag at destination length
// - Destination-half flag at half destination length
// - Block-done on larger length moved or match
// ****************************************************************
`include "dps_defines.svh"

module dps_channel (
    input wire logic i_clk,                             // System clock, 40 MHz.
    input wire logic i_rst,                             // Synchronous reset, active high.
    input wire logic [`DPS_ADDR_W-1:0] i_addr,          // Register byte address.
    input wire logic [31:0] i_wdata,                    // Write data.
    input wire logic i_wr,                              // Write strobe.
    input wire logic i_rd,                              // Read strobe.
    output logic [31:0] o_rdata,                        // Read data, cycle after strobe.
    input wire logic i_xfer,                            // A bus transfer moved bytes.
    input wire dps_pkg::dps_step_t i_xfer_bytes,        // Bytes moved, 1 to 4.
    input wire logic i_pattern_match,                   // Pattern matched this cycle.
    input wire dps_pkg::dps_len_t i_source_length,      // Source length, zero is 65,536.
    output logic o_block_done,                          // Block finished, one-cycle pulse.
    output logic o_irq                                  // Interrupt, level.
);
    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic sel_ctrl = (i_addr == `DPS_OFS_CTRL);
    wire logic sel_dlen = (i_addr == `DPS_OFS_DLEN);
    wire logic sel_sprog = (i_addr == `DPS_OFS_SPROG);
    wire logic sel_dprog = (i_addr == `DPS_OFS_DPROG);
    wire logic sel_clen = (i_addr == `DPS_OFS_CLEN);
    wire logic sel_cprog = (i_addr == `DPS_OFS_CPROG);
    wire logic sel_stat = (i_addr == `DPS_OFS_STAT);
    wire logic sel_mask = (i_addr == `DPS_OFS_MASK);
    wire logic wr_ctrl = i_wr && sel_ctrl;
    wire logic wr_dlen = i_wr && sel_dlen;
    wire logic wr_clen = i_wr && sel_clen;
    wire logic wr_stat = i_wr && sel_stat;
    wire logic wr_mask = i_wr && sel_mask;

    // ****************************************************************
    // Software-written configuration
    // ****************************************************************
    logic pattern_mode;
    dps_pkg::dps_len_t dest_len;
    dps_pkg::dps_len_t cell_len;

    // Only the low half of each length write, and bit 0 of a control write, is kept; the upper half has no storage.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pattern_mode <= 1'b0;
            dest_len <= `DPS_LEN_RESET;
            cell_len <= `DPS_LEN_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                pattern_mode <= i_wdata[`DPS_CTRL_PAT_BIT];
            end
            if (wr_dlen)
            begin
                dest_len <= i_wdata[15:0];
            end
            if (wr_clen)
            begin
                cell_len <= i_wdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Progress trackers
    // ****************************************************************
    dps_if src_if ();
    dps_if dst_if ();
    dps_if cel_if ();

    wire logic pat_hit = pattern_mode && i_pattern_match;

    assign src_if.advance = i_xfer;
    assign src_if.step = i_xfer_bytes;
    assign src_if.clear = pat_hit;
    assign src_if.length = i_source_length;

    assign dst_if.advance = i_xfer;
    assign dst_if.step = i_xfer_bytes;
    assign dst_if.clear = 1'b0;
    assign dst_if.length = dest_len;

    // The cell count restarts every time a whole cell has moved, which marks the next event.
    assign cel_if.advance = i_xfer;
    assign cel_if.step = i_xfer_bytes;
    assign cel_if.clear = pat_hit;
    assign cel_if.length = cell_len;

    dps_track u_src (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .t(src_if)
    );

    dps_track u_dst (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .t(dst_if)
    );

    dps_track u_cel (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .t(cel_if)
    );

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    dps_pkg::dps_lim_t src_lim;
    dps_pkg::dps_lim_t dst_lim;
    logic [`DPS_NUM_FLAGS-1:0] events;
    logic [`DPS_NUM_FLAGS-1:0] status;
    logic [`DPS_NUM_FLAGS-1:0] mask;
    logic [`DPS_NUM_FLAGS-1:0] stat_clear;

    assign src_lim = dps_pkg::dps_eff_len(i_source_length);
    assign dst_lim = dps_pkg::dps_eff_len(dest_len);

    // The side with the longer span finishes last, so its wrap ends the block.
    wire logic block_ev = pat_hit || ((src_lim > dst_lim) ? src_if.done : dst_if.done);

    assign events[`DPS_FLAG_CELL] = cel_if.done;
    assign events[`DPS_FLAG_BLOCK] = block_ev;
    assign events[`DPS_FLAG_DHALF] = dst_if.half;
    assign events[`DPS_FLAG_DDONE] = dst_if.done;
    assign stat_clear = wr_stat ? i_wdata[`DPS_NUM_FLAGS-1:0] : '0;

    dps_irq #(
        .N(`DPS_NUM_FLAGS)
    ) u_irq (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_event(events),
        .i_clear(stat_clear),
        .i_mask_we(wr_mask),
        .i_mask_wdata(i_wdata[`DPS_NUM_FLAGS-1:0]),
        .o_status(status),
        .o_mask(mask),
        .o_irq(o_irq)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] rd_word;

    assign rd_word = sel_ctrl ? {31'h0000_0000, pattern_mode}
        : sel_dlen ? {16'h0000, dest_len}
        : sel_sprog ? {16'h0000, src_if.index}
        : sel_dprog ? {16'h0000, dst_if.index}
        : sel_clen ? {16'h0000, cell_len}
        : sel_cprog ? {16'h0000, cel_if.index}
        : sel_stat ? {28'h000_0000, status}
        : sel_mask ? {28'h000_0000, mask}
        : 32'h0000_0000;

    // Data is held only for the cycle after a read, so stale words never linger on the bus.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= 32'h0000_0000;
            o_block_done <= 1'b0;
        end
        else
        begin
            o_rdata <= i_rd ? rd_word : 32'h0000_0000;
            o_block_done <= block_ev;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_upper_zero;
        (i_rd && (sel_dlen || sel_sprog || sel_dprog || sel_clen || sel_cprog)) |=> (o_rdata[31:16] == 16'h0000);
    endproperty
    property p_dlen_back;
        (i_wr && sel_dlen) ##1 (i_rd && sel_dlen) |=> (o_rdata == {16'h0000, $past(i_wdata[15:0], 2)});
    endproperty
    property p_clen_back;
        (i_wr && sel_clen) ##1 (i_rd && sel_clen) |=> (o_rdata == {16'h0000, $past(i_wdata[15:0], 2)});
    endproperty
    property p_src_read;
        (i_rd && sel_sprog) |=> (o_rdata[15:0] == $past(src_if.index));
    endproperty
    property p_dst_read;
        (i_rd && sel_dprog) |=> (o_rdata[15:0] == $past(dst_if.index));
    endproperty
    property p_pat_clear;
        pat_hit |=> (src_if.index == 16'h0000) && (cel_if.index == 16'h0000);
    endproperty
    property p_cell_flag;
        cel_if.done |=> status[`DPS_FLAG_CELL];
    endproperty
    property p_ddone_flag;
        dst_if.done |=> status[`DPS_FLAG_DDONE] && (dst_if.index == 16'h0000);
    endproperty
    property p_dhalf_flag;
        dst_if.half |=> status[`DPS_FLAG_DHALF];
    endproperty
    property p_block_flag;
        pat_hit |=> status[`DPS_FLAG_BLOCK] && o_block_done;
    endproperty
    property p_irq_level;
        o_irq == |(status & mask);
    endproperty
    property p_cprog_read;
        (i_rd && sel_cprog) |=> (o_rdata[15:0] == $past(cel_if.index));
    endproperty
    property p_rdata_idle;
        !i_rd |=> (o_rdata == 32'h0000_0000);
    endproperty
    property p_dlen_hold;
        !wr_dlen |=> (dest_len == $past(dest_len));
    endproperty
    property p_clen_hold;
        !wr_clen |=> (cell_len == $past(cell_len));
    endproperty
    property p_dst_keeps;
        (pat_hit && i_xfer && !dst_if.done) |=> (dst_if.index == 16'($past(dst_if.index) + $past(i_xfer_bytes)));
    endproperty
    property p_cell_wrap;
        cel_if.done |=> (cel_if.index == 16'h0000);
    endproperty
    property p_block_dst;
        (dst_if.done && (dst_lim >= src_lim)) |=> o_block_done && status[`DPS_FLAG_BLOCK];
    endproperty
    property p_block_src;
        (src_if.done && (src_lim > dst_lim)) |=> o_block_done && status[`DPS_FLAG_BLOCK];
    endproperty
    property p_block_quiet;
        (!pat_hit && !src_if.done && !dst_if.done) |=> !o_block_done;
    endproperty

    a_upper_zero: assert property (p_upper_zero) else $error("Upper half not zero.");
    a_dlen_back: assert property (p_dlen_back) else $error("Destination length lost.");
    a_clen_back: assert property (p_clen_back) else $error("Cell length lost.");
    a_src_read: assert property (p_src_read) else $error("Source index misread.");
    a_dst_read: assert property (p_dst_read) else $error("Destination index misread.");
    a_pat_clear: assert property (p_pat_clear) else $error("Match did not clear counts.");
    a_cell_flag: assert property (p_cell_flag) else $error("Cell flag missing.");
    a_ddone_flag: assert property (p_ddone_flag) else $error("Destination done missing.");
    a_dhalf_flag: assert property (p_dhalf_flag) else $error("Destination half missing.");
    a_block_flag: assert property (p_block_flag) else $error("Block flag missing.");
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong.");
    a_cprog_read: assert property (p_cprog_read) else $error("Cell count misread.");
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not idle.");
    a_dlen_hold: assert property (p_dlen_hold) else $error("Destination length changed.");
    a_clen_hold: assert property (p_clen_hold) else $error("Cell length changed.");
    a_dst_keeps: assert property (p_dst_keeps) else $error("Match disturbed destination index.");
    a_cell_wrap: assert property (p_cell_wrap) else $error("Cell count did not restart.");
    a_block_dst: assert property (p_block_dst) else $error("Block end on destination missing.");
    a_block_src: assert property (p_block_src) else $error("Block end on source missing.");
    a_block_quiet: assert property (p_block_quiet) else $error("Spurious block end.");

    c_cell_done: cover property (cel_if.done);
    c_dest_half: cover property (dst_if.half);
    c_pattern: cover property (pat_hit);
    c_irq: cover property (o_irq);
    c_block: cover property (o_block_done);

    // ****************************************************************
    // Per-flag status checks
    // ****************************************************************
    // An event must win over a clear in the same cycle, and a set bit may drop only on a clear.
    for (genvar f = 0; f < `DPS_NUM_FLAGS; f++)
    begin : g_flag
        property p_flag_sticky;
            @(posedge i_clk) disable iff (i_rst) (status[f] && !stat_clear[f]) |=> status[f];
        endproperty
        property p_flag_clear;
            @(posedge i_clk) disable iff (i_rst) (stat_clear[f] && !events[f]) |=> !status[f];
        endproperty
        property p_flag_set;
            @(posedge i_clk) disable iff (i_rst) events[f] |=> status[f];
        endproperty
        a_flag_sticky: assert property (p_flag_sticky) else $error("Status bit dropped.");
        a_flag_clear: assert property (p_flag_clear) else $error("Status bit not cleared.");
        a_flag_set: assert property (p_flag_set) else $error("Status bit not set.");
    end
endmodule : dps_channel

// ===== src/dps_defines.svh
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define DPS_ADDR_W 8
`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_DLEN 8'h04
`define DPS_OFS_SPROG 8'h08
`define DPS_OFS_DPROG 8'h0C
`define DPS_OFS_CLEN 8'h10
`define DPS_OFS_CPROG 8'h14
`define DPS_OFS_STAT 8'h18
`define DPS_OFS_MASK 8'h1C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DPS_CTRL_PAT_BIT 0
`define DPS_FLAG_CELL 0
`define DPS_FLAG_BLOCK 1
`define DPS_FLAG_DHALF 2
`define DPS_FLAG_DDONE 3
`define DPS_NUM_FLAGS 4
`define DPS_LEN_RESET 16'h0000
`define DPS_IDX_RESET 16'h0000
`define DPS_FULL_LEN 17'h10000

`endif

// ===== src/dps_if.sv
interface dps_if;
    logic advance;
    dps_pkg::dps_step_t step;
    logic clear;
    dps_pkg::dps_len_t length;
    dps_pkg::dps_len_t index;
    logic done;
    logic half;

    modport owner (output advance, step, clear, length, input index, done, half);
    modport track (input advance, step, clear, length, output index, done, half);
endinterface : dps_if

// ===== src/dps_irq.sv
module dps_irq #(
    parameter int N = 4
) (
    input wire logic i_clk,                 // System clock.
    input wire logic i_rst,                 // Synchronous reset, active high.
    input wire logic [N-1:0] i_event,       // One-cycle event pulses.
    input wire logic [N-1:0] i_clear,       // Ones clear status bits.
    input wire logic i_mask_we,             // Mask write strobe.
    input wire logic [N-1:0] i_mask_wdata,  // New mask value.
    output logic [N-1:0] o_status,          // Sticky status bits.
    output logic [N-1:0] o_mask,            // Interrupt mask.
    output logic o_irq                      // Level interrupt.
);
    logic [N-1:0] next_status;
    logic [N-1:0] next_mask;

    // A new event outranks a clear that lands in the same cycle.
    assign next_status = (o_status & ~i_clear) | i_event;
    assign next_mask = i_mask_we ? i_mask_wdata : o_mask;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_status <= '0;
            o_mask <= '0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_status <= next_status;
            o_mask <= next_mask;
            o_irq <= |(next_status & next_mask);
        end
    end
endmodule : dps_irq

// ===== src/dps_pkg.sv
`include "dps_defines.svh"

package dps_pkg;
    typedef logic [15:0] dps_len_t;
    typedef logic [2:0] dps_step_t;
    typedef logic [16:0] dps_lim_t;

    // A stored length of zero stands for the full 64 KiB span.
    function automatic dps_lim_t dps_eff_len(input dps_len_t len);
        return (len == 16'h0000) ? `DPS_FULL_LEN : {1'b0, len};
    endfunction : dps_eff_len
endpackage : dps_pkg

// ===== src/dps_track.sv
`include "dps_defines.svh"

module dps_track (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    dps_if.track t          // Progress channel.
);
    dps_pkg::dps_lim_t lim;
    dps_pkg::dps_lim_t mid;
    dps_pkg::dps_lim_t sum;

    assign lim = dps_pkg::dps_eff_len(t.length);
    assign mid = {1'b0, lim[16:1]};
    assign sum = {1'b0, t.index} + {14'h0, t.step};
    assign t.done = t.advance && !t.clear && (sum >= lim);
    assign t.half = t.advance && !t.clear && ({1'b0, t.index} < mid) && (sum >= mid);

    // A clear beats a transfer in the same cycle, so a match never leaves a stale count.
    always_ff @(posedge i_clk)
    begin
        if (i_rst || t.clear)
        begin
            t.index <= `DPS_IDX_RESET;
        end
        else if (t.done)
        begin
            t.index <= `DPS_IDX_RESET;
        end
        else if (t.advance)
        begin
            t.index <= sum[15:0];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Software may shrink a length under a running index, so only indexes just written are bounded.
    property p_track_bound;
        (t.advance || t.clear) |=> ({1'b0, t.index} < $past(lim));
    endproperty
    property p_track_step;
        (t.advance && !t.clear && !t.done) |=> (t.index == 16'($past(t.index) + $past(t.step)));
    endproperty
    a_track_bound: assert property (p_track_bound) else $error("Index reached its length.");
    a_track_step: assert property (p_track_step) else $error("Index did not advance by step.");
endmodule : dps_track
